//--- ddrt_pkg.sv
// Shared constants for the DDR3 device-side command timing block.
// Assumes command pins use the usual cs/ras/cas/we order, MSB first.
package ddrt_pkg;

  // Counter width for clock-count timers
  localparam int CNT_W = 8;
  // Depth of the write-start delay line, covers WL up to 12 plus 4
  localparam int PIPE_W = 16;

  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_ZQ  = 4'h6;

  // Mode register selects on the bank pins
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR2 = 3'h2;

  // Address bit positions
  localparam int BL_LO  = 0;
  localparam int BL_HI  = 1;
  localparam int CWL_LO = 3;
  localparam int CWL_HI = 5;
  localparam int WR_LO  = 9;
  localparam int WR_HI  = 11;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // Burst length field encodings
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;

  // Clock counts
  localparam logic [CNT_W-1:0] CWL_BASE   = 8'h05;
  localparam logic [CNT_W-1:0] WS_DLY_8   = 8'h04;
  localparam logic [CNT_W-1:0] WS_DLY_4   = 8'h02;
  localparam logic [CNT_W-1:0] ZQCS_NCK   = 8'h40;
  localparam logic [CNT_W-1:0] WR_RST_NCK = 8'h05;
  localparam logic [CNT_W-1:0] WL_RST_NCK = 8'h05;

  // Write recovery field to clock count
  function automatic logic [CNT_W-1:0] wr_decode(input logic [2:0] code);
    logic [CNT_W-1:0] v;
    v = 8'h10;
    unique case (code)
      3'h1: v = 8'h05;
      3'h2: v = 8'h06;
      3'h3: v = 8'h07;
      3'h4: v = 8'h08;
      3'h5: v = 8'h0A;
      3'h6: v = 8'h0C;
      3'h7: v = 8'h0E;
      3'h0: v = 8'h10;
    endcase
    return v;
  endfunction

endpackage

//--- ddrt_timer.sv
// Down-counter that stretches to the longest pending load.
// Assumes tick is a one-cycle strobe on each memory clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module ddrt_timer #(
  parameter int W = ddrt_pkg::CNT_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy,
  output logic              expire
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } ddrt_tmr_t;

  ddrt_tmr_t st_r;
  ddrt_tmr_t st_nxt;

  // Count memory edges, keep the longer of running and new load
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.exp = 1'b0;
    if (tick && st_r.cnt != '0)
    begin
      st_nxt.cnt = st_r.cnt - W'(1);
      st_nxt.exp = (st_r.cnt == W'(1));
    end
    if (load && load_val > st_nxt.cnt)
    begin
      st_nxt.cnt = load_val;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy   = (st_r.cnt != '0);
  assign expire = st_r.exp;

endmodule
`default_nettype wire

//--- ddrt_core.sv
// DDR3 device-side command timing: write start, busy tracking,
// power-down entry, short ZQ calibration window.
// Assumes memory clock and command pins come from an outside controller.
`timescale 1ns/1ps
`default_nettype none
module ddrt_core #(
  parameter int ADDR_W = 16,
  parameter int TCK_PS = 320000,
  parameter int ACT_PS = 13750,
  parameter int PRE_PS = 13750,
  parameter int REF_PS = 260000
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      mem_ck,
  input  wire logic                      cke,
  input  wire logic                      cs_b,
  input  wire logic                      ras_b,
  input  wire logic                      cas_b,
  input  wire logic                      we_b,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [2:0]                bank,
  output logic                           wr_start,
  output logic                           row_busy,
  output logic                           pd_entered,
  output logic                           pd_low_power,
  output logic                           zq_active,
  output logic                           zq_done,
  output logic [ddrt_pkg::CNT_W-1:0]     wr_recovery_nck,
  output logic [ddrt_pkg::CNT_W-1:0]     write_latency_nck,
  output logic [1:0]                     burst_mode
);

  localparam int CW = ddrt_pkg::CNT_W;
  localparam int PW = ddrt_pkg::PIPE_W;
  localparam int NTMR = 2;
  localparam int TMR_ROW = 0;
  localparam int TMR_ZQ = 1;

  // Device-side busy times, rounded up to whole memory clocks
  localparam int ACT_RAW = (ACT_PS + TCK_PS - 1) / TCK_PS;
  localparam int PRE_RAW = (PRE_PS + TCK_PS - 1) / TCK_PS;
  localparam int REF_RAW = (REF_PS + TCK_PS - 1) / TCK_PS;
  localparam logic [CW-1:0] ACT_NCK = CW'((ACT_RAW < 1) ? 1 : ACT_RAW);
  localparam logic [CW-1:0] PRE_NCK = CW'((PRE_RAW < 1) ? 1 : PRE_RAW);
  localparam logic [CW-1:0] REF_NCK = CW'((REF_RAW < 1) ? 1 : REF_RAW);

  typedef struct packed {
    logic              ck_m;
    logic              ck_s;
    logic              ck_d;
    logic              cke_m;
    logic              cke_s;
    logic [3:0]        cmd_m;
    logic [3:0]        cmd_s;
    logic [ADDR_W-1:0] addr_m;
    logic [ADDR_W-1:0] addr_s;
    logic [2:0]        ba_m;
    logic [2:0]        ba_s;
    logic [1:0]        bl_mode;
    logic [CW-1:0]     wr_nck;
    logic [CW-1:0]     wl_nck;
    logic [PW-1:0]     ws_pipe;
    logic              ws_pulse;
    logic              pd;
  } ddrt_state_t;

  ddrt_state_t st_r;
  ddrt_state_t st_nxt;

  logic              ck_rise;
  logic              cmd_valid;
  logic [CW-1:0]     ws_dly;
  logic [NTMR-1:0]   tmr_load;
  logic [CW-1:0]     tmr_val [NTMR];
  logic [NTMR-1:0]   tmr_busy;
  logic [NTMR-1:0]   tmr_exp;

  // Memory clock edge found on the synchronised copy
  assign ck_rise   = st_r.ck_s & ~st_r.ck_d;
  assign cmd_valid = ck_rise & st_r.cke_s;

  // Write start offset is shorter only in fixed chop mode; on-the-fly mode uses the eight offset
  always_comb
  begin
    if (st_r.bl_mode == ddrt_pkg::BL_FIX4)
      ws_dly = st_r.wl_nck + ddrt_pkg::WS_DLY_4;
    else
      ws_dly = st_r.wl_nck + ddrt_pkg::WS_DLY_8;
  end

  // Timer loads from the command registered on this edge
  always_comb
  begin
    tmr_load = '0;
    tmr_val[TMR_ROW] = '0;
    tmr_val[TMR_ZQ] = ddrt_pkg::ZQCS_NCK;
    if (cmd_valid)
    begin
      unique case (st_r.cmd_s)
        ddrt_pkg::CMD_ACT:
        begin
          tmr_load[TMR_ROW] = 1'b1;
          tmr_val[TMR_ROW]  = ACT_NCK;
        end
        ddrt_pkg::CMD_PRE:
        begin
          tmr_load[TMR_ROW] = 1'b1;
          tmr_val[TMR_ROW]  = PRE_NCK;
        end
        ddrt_pkg::CMD_REF:
        begin
          tmr_load[TMR_ROW] = 1'b1;
          tmr_val[TMR_ROW]  = REF_NCK;
        end
        ddrt_pkg::CMD_WR:
        begin
          // Auto-precharge waits write start plus programmed recovery
          tmr_load[TMR_ROW] = st_r.addr_s[ddrt_pkg::AP_BIT];
          tmr_val[TMR_ROW]  = ws_dly + st_r.wr_nck + PRE_NCK;
        end
        ddrt_pkg::CMD_RD:
        begin
          tmr_load[TMR_ROW] = st_r.addr_s[ddrt_pkg::AP_BIT];
          tmr_val[TMR_ROW]  = ddrt_pkg::WS_DLY_8 + PRE_NCK;
        end
        ddrt_pkg::CMD_ZQ:
        begin
          // Short calibration has A10 low
          tmr_load[TMR_ZQ] = ~st_r.addr_s[ddrt_pkg::AP_BIT];
        end
        default:
        begin
          tmr_load = '0;
        end
      endcase
    end
  end

  // One down-counter per tracked activity, ticked by memory edges
  generate
    for (genvar i = 0; i < NTMR; i++)
    begin : g_tmr
      ddrt_timer #(
        .W        (CW)
      ) u_tmr (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .tick     (ck_rise),
        .load     (tmr_load[i]),
        .load_val (tmr_val[i]),
        .busy     (tmr_busy[i]),
        .expire   (tmr_exp[i])
      );
    end
  endgenerate

  // Pin synchronisers, mode capture, write-start delay line, power-down
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ck_m   = mem_ck;
    st_nxt.ck_s   = st_r.ck_m;
    st_nxt.ck_d   = st_r.ck_s;
    st_nxt.cke_m  = cke;
    st_nxt.cke_s  = st_r.cke_m;
    st_nxt.cmd_m  = {cs_b, ras_b, cas_b, we_b};
    st_nxt.cmd_s  = st_r.cmd_m;
    st_nxt.addr_m = addr;
    st_nxt.addr_s = st_r.addr_m;
    st_nxt.ba_m   = bank;
    st_nxt.ba_s   = st_r.ba_m;
    st_nxt.ws_pulse = 1'b0;
    if (ck_rise)
    begin
      // Delay line advances one memory edge at a time
      st_nxt.ws_pulse = st_r.ws_pipe[0];
      st_nxt.ws_pipe  = st_r.ws_pipe >> 1;
      // Clock enable low is accepted even with work in flight
      st_nxt.pd = ~st_r.cke_s;
    end
    if (cmd_valid && st_r.cmd_s == ddrt_pkg::CMD_WR)
    begin
      st_nxt.ws_pipe = st_nxt.ws_pipe | (PW'(1) << (ws_dly - CW'(1)));
    end
    if (cmd_valid && st_r.cmd_s == ddrt_pkg::CMD_MRS)
    begin
      if (st_r.ba_s == ddrt_pkg::BA_MR0)
      begin
        st_nxt.bl_mode = st_r.addr_s[ddrt_pkg::BL_HI:ddrt_pkg::BL_LO];
        st_nxt.wr_nck  = ddrt_pkg::wr_decode(
                           st_r.addr_s[ddrt_pkg::WR_HI:ddrt_pkg::WR_LO]);
      end
      if (st_r.ba_s == ddrt_pkg::BA_MR2)
      begin
        st_nxt.wl_nck = ddrt_pkg::CWL_BASE
                      + CW'(st_r.addr_s[ddrt_pkg::CWL_HI:ddrt_pkg::CWL_LO]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r         <= '0;
      st_r.bl_mode <= ddrt_pkg::BL_FIX8;
      st_r.wr_nck  <= ddrt_pkg::WR_RST_NCK;
      st_r.wl_nck  <= ddrt_pkg::WL_RST_NCK;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign wr_start          = st_r.ws_pulse;
  assign row_busy          = tmr_busy[TMR_ROW];
  assign pd_entered        = st_r.pd;
  assign pd_low_power      = st_r.pd & ~tmr_busy[TMR_ROW];
  assign zq_active         = tmr_busy[TMR_ZQ];
  assign zq_done           = tmr_exp[TMR_ZQ];
  assign wr_recovery_nck   = st_r.wr_nck;
  assign write_latency_nck = st_r.wl_nck;
  assign burst_mode        = st_r.bl_mode;

endmodule
`default_nettype wire

//--- ddrt_props.sv
// Checker for the ddrt_core output timing.
// Assumes a free-running 320 ns memory clock from outside.
`timescale 1ns/1ps
`default_nettype none
module ddrt_props (
  input wire logic                        ref_clk,
  input wire logic                        rst_b,
  input wire logic                        mem_ck,
  input wire logic                        cke,
  input wire logic                        cs_b,
  input wire logic                        ras_b,
  input wire logic                        cas_b,
  input wire logic                        we_b,
  input wire logic                        wr_start,
  input wire logic                        row_busy,
  input wire logic                        pd_entered,
  input wire logic                        pd_low_power,
  input wire logic                        zq_active,
  input wire logic                        zq_done,
  input wire logic [ddrt_pkg::CNT_W-1:0]  wr_recovery_nck,
  input wire logic [ddrt_pkg::CNT_W-1:0]  write_latency_nck,
  input wire logic [1:0]                  burst_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Write start spacing with a latency of five memory clocks
  a_wr_start_long: assert property (
    $rose(mem_ck) && cke && {cs_b, ras_b, cas_b, we_b} == ddrt_pkg::CMD_WR
    && write_latency_nck == 8'h05 && burst_mode != ddrt_pkg::BL_FIX4 |-> ##[72:80] wr_start)
    else $error("write start not nine memory clocks after write");
  a_wr_start_chop: assert property (
    $rose(mem_ck) && cke && {cs_b, ras_b, cas_b, we_b} == ddrt_pkg::CMD_WR
    && write_latency_nck == 8'h05 && burst_mode == ddrt_pkg::BL_FIX4 |-> ##[56:64] wr_start)
    else $error("write start not seven memory clocks after write");
  // Power-down entry and its current state
  a_pd_accept: assert property ($rose(mem_ck) && !cke |-> ##[2:10] pd_entered)
    else $error("clock enable low not taken");
  a_pd_gate: assert property (pd_low_power == (pd_entered && !row_busy))
    else $error("low power state while busy or not in power down");
  // Short calibration window
  a_zq_window: assert property ($rose(zq_active) |-> ##[504:520] zq_done)
    else $error("short calibration not done in 64 memory clocks");
  a_zq_end: assert property (zq_done |-> !zq_active && $past(zq_active))
    else $error("calibration done pulse out of place");
  a_wr_code: assert property (wr_recovery_nck inside {8'h05, 8'h06, 8'h07, 8'h08,
    8'h0A, 8'h0C, 8'h0E, 8'h10}) else $error("write recovery count not legal");
endmodule
bind ddrt_core ddrt_props u_props (.ref_clk, .rst_b, .mem_ck, .cke, .cs_b, .ras_b, .cas_b,
  .we_b, .wr_start, .row_busy, .pd_entered, .pd_low_power, .zq_active, .zq_done,
  .wr_recovery_nck, .write_latency_nck, .burst_mode);
`default_nettype wire

//--- ddrt_ctrl_model.sv
// Memory controller stand-in: free-running memory clock and command pins.
// Assumes a 25 MHz block clock; the memory clock is one eighth of it.
`timescale 1ns/1ps
`default_nettype none
module ddrt_ctrl_model (
  input  wire logic         ref_clk,
  output var  logic         mem_ck,
  output var  logic         cke,
  output var  logic [3:0]   cmd_b,
  output var  logic [15:0]  addr,
  output var  logic [2:0]   bank
);
  logic [1:0] div = 2'h0;
  initial
  begin
    mem_ck = 1'b0;
    cke = 1'b1;
    cmd_b = 4'hF;
    addr = 16'h0000;
    bank = 3'h0;
  end
  // Memory clock, toggled every fourth falling block clock edge
  always @(negedge ref_clk)
  begin
    div <= div + 2'h1;
    if (div == 2'h3)
      mem_ck <= ~mem_ck;
  end
  // One command held across a whole memory clock, then deselect
  task automatic cmd(input logic [3:0] code, input logic [2:0] ba, input logic [15:0] a);
    @(negedge mem_ck);
    cmd_b = code;
    bank = ba;
    addr = a;
    @(posedge mem_ck);
    @(negedge mem_ck);
    cmd_b = 4'hF;
    addr = ~a;
  endtask
  task automatic set_cke(input logic v);
    @(negedge mem_ck);
    cke = v;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for ddrt_core driven by a controller stand-in.
// Assumes a 25 MHz block clock and a 320 ns memory clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int ACT_PS = 1000000;
  localparam int ACT_N  = (ACT_PS + 319999) / 320000;
  logic        ref_clk, rst_b, mem_ck, cke, wr_start, row_busy;
  logic        pd_entered, pd_low_power, zq_active, zq_done;
  logic [3:0]  cmd_b;
  logic [15:0] addr;
  logic [2:0]  bank;
  logic [7:0]  wr_rec, wl;
  logic [1:0]  bmode;
  int          error_cnt = 0, num_checks = 0, cyc = 0, ck_cnt = 0;
  ddrt_ctrl_model ctl (.ref_clk(ref_clk), .mem_ck(mem_ck), .cke(cke), .cmd_b(cmd_b),
    .addr(addr), .bank(bank));
  ddrt_core #(.ACT_PS(ACT_PS)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .mem_ck(mem_ck),
    .cke(cke), .cs_b(cmd_b[3]), .ras_b(cmd_b[2]), .cas_b(cmd_b[1]), .we_b(cmd_b[0]),
    .addr(addr), .bank(bank), .wr_start(wr_start), .row_busy(row_busy),
    .pd_entered(pd_entered), .pd_low_power(pd_low_power), .zq_active(zq_active),
    .zq_done(zq_done), .wr_recovery_nck(wr_rec), .write_latency_nck(wl), .burst_mode(bmode));
  // Block clock, memory edge count and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge mem_ck) ck_cnt++;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Memory edges after the issuing edge until the chosen pulse shows
  task automatic wait_pulse(input bit zq, output int n);
    int c0;
    c0 = ck_cnt;
    repeat (1000)
    begin
      @(negedge ref_clk);
      if ((zq ? zq_done : wr_start) === 1'b1)
        break;
    end
    n = ck_cnt - c0;
  endtask
  // Every write recovery code of mode register 0, then a latency code
  task automatic t_mode_regs();
    logic [7:0] tbl[8] = '{8'h10, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0C, 8'h0E};
    for (int c = 0; c < 8; c++)
    begin
      ctl.cmd(ddrt_pkg::CMD_MRS, ddrt_pkg::BA_MR0, {4'h0, 3'(c), 9'h000});
      repeat (8) @(negedge ref_clk);
      chk(wr_rec, tbl[c]);
    end
    ctl.cmd(ddrt_pkg::CMD_MRS, ddrt_pkg::BA_MR2, 16'h0008);
    repeat (8) @(negedge ref_clk);
    chk(wl, 8'h06);
  endtask
  // Write start for fixed eight, chop on the fly, eight on the fly, fixed chop, longer latency
  task automatic t_write();
    logic [1:0] bm[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      ctl.cmd(ddrt_pkg::CMD_MRS, ddrt_pkg::BA_MR2, {10'h000, 3'(i / 4), 3'h0});
      ctl.cmd(ddrt_pkg::CMD_MRS, ddrt_pkg::BA_MR0, {14'h0000, bm[i]});
      repeat (8) @(negedge ref_clk);
      chk({6'h00, bmode}, {6'h00, bm[i]});
      ctl.cmd(ddrt_pkg::CMD_WR, 3'h0, {3'h0, i == 2, 12'h000});
      wait_pulse(1'b0, n);
      chk(8'(n), 8'(5 + i / 4 + (bm[i] == 2'h2 ? 2 : 4)));
    end
  endtask
  // Short calibration length, long calibration ignored
  task automatic t_zq();
    int n;
    ctl.cmd(ddrt_pkg::CMD_ZQ, 3'h0, 16'h0000);
    wait_pulse(1'b1, n);
    chk(8'(n), 8'd64);
    ctl.cmd(ddrt_pkg::CMD_ZQ, 3'h0, 16'h0400);
    repeat (16) @(negedge ref_clk);
    chk(zq_active, 1'b0);
  endtask
  // Memory edges until the row timer runs out
  task automatic wait_idle(output int n);
    int c0;
    c0 = ck_cnt;
    repeat (1000)
    begin
      @(negedge ref_clk);
      if (row_busy === 1'b0)
        break;
    end
    n = ck_cnt - c0;
  endtask
  // Busy length after refresh, precharge and both auto-precharge forms
  task automatic t_busy();
    int n;
    ctl.cmd(ddrt_pkg::CMD_REF, 3'h0, 16'h0000);
    wait_idle(n);
    chk(8'(n), 8'd1);
    ctl.cmd(ddrt_pkg::CMD_PRE, 3'h0, 16'h0000);
    wait_idle(n);
    chk(8'(n), 8'd1);
    ctl.cmd(ddrt_pkg::CMD_WR, 3'h0, 16'h0400);
    wait_idle(n);
    chk(8'(n), 8'(6 + 4 + 16 + 1));
    ctl.cmd(ddrt_pkg::CMD_RD, 3'h0, 16'h0400);
    wait_idle(n);
    chk(8'(n), 8'(4 + 1));
  endtask
  // Clock enable low while a row activation is still busy
  task automatic t_pd();
    ctl.cmd(ddrt_pkg::CMD_ACT, 3'h0, 16'h0000);
    ctl.set_cke(1'b0);
    repeat (12) @(negedge ref_clk);
    chk({pd_entered, row_busy, pd_low_power}, 8'h06);
    repeat (ACT_N * 8) @(negedge ref_clk);
    chk({pd_entered, row_busy, pd_low_power}, 8'h05);
    ctl.set_cke(1'b1);
    repeat (16) @(negedge ref_clk);
    chk(pd_entered, 1'b0);
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset, then each scenario in turn
  initial
  begin
    rst_b = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    chk(wr_rec, 8'h05);
    chk(wl, 8'h05);
    t_mode_regs();
    t_write();
    t_zq();
    t_busy();
    t_pd();
    final_report();
  end
endmodule
`default_nettype wire
